// ===== src/cefmb_defines.svh
// register offsets, bit positions and reset values of the flag and mask bank
`ifndef CEFMB_DEFINES_SVH
`define CEFMB_DEFINES_SVH
`define CEFMB_ADDR_CHG   8'h03
`define CEFMB_ADDR_FLT   8'h04
`define CEFMB_ADDR_OPEN  8'h05
`define CEFMB_ADDR_TMR   8'h06
`define CEFMB_ADDR_MASK  8'h07
`define CEFMB_RST_CHG    8'h00
`define CEFMB_RST_FLT    8'h00
`define CEFMB_RST_OPEN   8'h00
`define CEFMB_RST_TMR    8'h00
`define CEFMB_RST_MASK   8'h00
`define CEFMB_RD_NONE    8'h00
`define CEFMB_CHG_CV     6
`define CEFMB_CHG_DONE   5
`define CEFMB_CHG_ILIM   4
`define CEFMB_CHG_DPM    2
`define CEFMB_CHG_THERM  1
`define CEFMB_CHG_PG     0
`define CEFMB_FLT_OVP    7
`define CEFMB_FLT_RSV    6
`define CEFMB_FLT_OCP    5
`define CEFMB_FLT_UVLO   4
`define CEFMB_FLT_COLD   3
`define CEFMB_FLT_COOL   2
`define CEFMB_FLT_WARM   1
`define CEFMB_FLT_HOT    0
`define CEFMB_OPEN_TS    0
`define CEFMB_TMR_RSV_HI 7
`define CEFMB_TMR_WD     6
`define CEFMB_TMR_SAFE   5
`define CEFMB_TMR_REG    4
`define CEFMB_TMR_RSV_LO 3
`define CEFMB_TMR_WAKE1  2
`define CEFMB_TMR_WAKE2  1
`define CEFMB_TMR_RSTW   0
`endif

// ===== src/cefmb_pkg.sv
// types shared by the flag and mask bank
package cefmb_pkg;
  typedef logic [7:0] cefmb_byte_t;
endpackage

// ===== src/cefmb_top.sv
// event flag registers, charge event mask and interrupt pulse
//
// Contract
// - fault flag register at 0x4, reset zero, whole register cleared by read
// - register 0x5: bits 7-1 read zero, bit 0 clears on read
// - timer flag register at 0x6, reset zero, cleared by read
// - bit 7 of fault flags latches input overvoltage detection
// - fault bit 5 latches battery overcurrent; bit 6 reserved zero
// - fault bit 4 undervoltage flag, printed polarity: 1 means recovered
// - fault bits 3..0 latch cold, cool, warm, hot region entry
// - bit 0 of 0x5 latches thermistor open fault
// - timer bit 6 latches watchdog expiry; bit 7 reserved zero
// - timer bit 5 latches charge safety timer expiry
// - timer bit 4 latches regulator or load switch overcurrent
// - timer bits 2 and 1 latch wake timers; bit 3 reserved
// - timer bit 0 latches reset warning timer expiry
// - read-write mask register at 0x7, reset zero, 1 masks
// - mask bits 6 and 5 gate voltage mode entry and charge done
// - mask bits 4,2,1,0 gate current limit, dpm, thermal, power good
// - mask bits 7 and 3 reserved, writable, reset zero
// - power good flag on any change, none at powerup under lockout
// - charge flags at 0x3 clear on read, bits match mask bits
`include "cefmb_defines.svh"
module cefmb_top
  import cefmb_pkg::*;
#(
  parameter bit UVLO_PRINTED_POLARITY = 1'b1
) (
  input  wire  logic        clock,
  input  wire  logic        rst_n,
  input  wire  logic        reg_rd,
  input  wire  logic        reg_wr,
  input  wire  cefmb_byte_t reg_addr,
  input  wire  cefmb_byte_t reg_wdata,
  output       cefmb_byte_t reg_rdata,
  output       logic        reg_rvalid,
  output       logic        irq_pulse,
  input  wire  logic        cv_entry_event,
  input  wire  logic        charge_done_event,
  input  wire  logic        input_current_limit_event,
  input  wire  logic        input_dpm_event,
  input  wire  logic        thermal_regulation_event,
  input  wire  logic        input_power_good,
  input  wire  logic        input_overvoltage_event,
  input  wire  logic        battery_overcurrent_event,
  input  wire  logic        battery_undervoltage_lockout,
  input  wire  logic        therm_cold_entry,
  input  wire  logic        therm_cool_entry,
  input  wire  logic        therm_warm_entry,
  input  wire  logic        therm_hot_entry,
  input  wire  logic        therm_open_event,
  input  wire  logic        watchdog_expiry_event,
  input  wire  logic        safety_timer_expiry_event,
  input  wire  logic        regulator_overcurrent_event,
  input  wire  logic        button_wake_first_expiry,
  input  wire  logic        button_wake_second_expiry,
  input  wire  logic        button_reset_warning_expiry
);

  cefmb_byte_t charge_event_flags;
  cefmb_byte_t fault_event_flags;
  cefmb_byte_t thermistor_open_flags;
  cefmb_byte_t timer_fault_flags;
  cefmb_byte_t charge_event_masks;
  cefmb_byte_t set_chg;
  cefmb_byte_t set_flt;
  cefmb_byte_t set_open;
  cefmb_byte_t set_tmr;
  cefmb_byte_t next_chg;
  cefmb_byte_t next_flt;
  cefmb_byte_t next_open;
  cefmb_byte_t next_tmr;
  cefmb_byte_t next_rdata;
  logic        clr_chg;
  logic        clr_flt;
  logic        clr_open;
  logic        clr_tmr;
  logic        started;
  logic        pg_prev;
  logic        uvlo_prev;
  logic        pg_change;
  logic        uvlo_edge;
  logic        pg_suppress;
  logic        next_irq;

  // clear-then-set: a set arriving with the clear survives
  function automatic cefmb_byte_t flag_next(input cefmb_byte_t cur,
                                            input logic        clr,
                                            input cefmb_byte_t set);
    flag_next = (cur & ~{8{clr}}) | set;
  endfunction

  // bits that go from 0 to 1 this cycle
  function automatic cefmb_byte_t rising(input cefmb_byte_t cur,
                                         input cefmb_byte_t nxt);
    rising = nxt & ~cur;
  endfunction

  function automatic logic rd_hit(input logic        rd,
                                  input cefmb_byte_t addr,
                                  input cefmb_byte_t off);
    rd_hit = rd && (addr == off);
  endfunction

  assign clr_chg  = rd_hit(reg_rd, reg_addr, `CEFMB_ADDR_CHG);
  assign clr_flt  = rd_hit(reg_rd, reg_addr, `CEFMB_ADDR_FLT);
  assign clr_open = rd_hit(reg_rd, reg_addr, `CEFMB_ADDR_OPEN);
  assign clr_tmr  = rd_hit(reg_rd, reg_addr, `CEFMB_ADDR_TMR);

  // powerup tracking; first cycle after release has no history yet
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      started   <= 1'b0;
      pg_prev   <= 1'b0;
      uvlo_prev <= 1'b0;
    end else begin
      started   <= 1'b1;
      pg_prev   <= input_power_good;
      uvlo_prev <= battery_undervoltage_lockout;
    end
  end

  assign pg_suppress = !started && input_power_good &&
                       battery_undervoltage_lockout;
  assign pg_change   = (input_power_good ^ pg_prev) && !pg_suppress;

  // printed polarity latches recovery out of lockout
  assign uvlo_edge = started &&
    (UVLO_PRINTED_POLARITY ?
       (uvlo_prev && !battery_undervoltage_lockout) :
       (!uvlo_prev && battery_undervoltage_lockout));

  always_comb begin
    set_chg = '0;
    set_chg[`CEFMB_CHG_CV]    = cv_entry_event;
    set_chg[`CEFMB_CHG_DONE]  = charge_done_event;
    set_chg[`CEFMB_CHG_ILIM]  = input_current_limit_event;
    set_chg[`CEFMB_CHG_DPM]   = input_dpm_event;
    set_chg[`CEFMB_CHG_THERM] = thermal_regulation_event;
    set_chg[`CEFMB_CHG_PG]    = pg_change;
  end

  always_comb begin
    set_flt = '0;
    set_flt[`CEFMB_FLT_OVP]  = input_overvoltage_event;
    set_flt[`CEFMB_FLT_OCP]  = battery_overcurrent_event;
    set_flt[`CEFMB_FLT_UVLO] = uvlo_edge;
    set_flt[`CEFMB_FLT_COLD] = therm_cold_entry;
    set_flt[`CEFMB_FLT_COOL] = therm_cool_entry;
    set_flt[`CEFMB_FLT_WARM] = therm_warm_entry;
    set_flt[`CEFMB_FLT_HOT]  = therm_hot_entry;
  end

  always_comb begin
    set_open = '0;
    set_open[`CEFMB_OPEN_TS] = therm_open_event;
  end

  always_comb begin
    set_tmr = '0;
    set_tmr[`CEFMB_TMR_WD]    = watchdog_expiry_event;
    set_tmr[`CEFMB_TMR_SAFE]  = safety_timer_expiry_event;
    set_tmr[`CEFMB_TMR_REG]   = regulator_overcurrent_event;
    set_tmr[`CEFMB_TMR_WAKE1] = button_wake_first_expiry;
    set_tmr[`CEFMB_TMR_WAKE2] = button_wake_second_expiry;
    set_tmr[`CEFMB_TMR_RSTW]  = button_reset_warning_expiry;
  end

  assign next_chg  = flag_next(charge_event_flags, clr_chg, set_chg);
  assign next_flt  = flag_next(fault_event_flags, clr_flt, set_flt);
  assign next_open = flag_next(thermistor_open_flags, clr_open, set_open);
  assign next_tmr  = flag_next(timer_fault_flags, clr_tmr, set_tmr);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      charge_event_flags    <= `CEFMB_RST_CHG;
      fault_event_flags     <= `CEFMB_RST_FLT;
      thermistor_open_flags <= `CEFMB_RST_OPEN;
      timer_fault_flags     <= `CEFMB_RST_TMR;
    end else begin
      charge_event_flags    <= next_chg;
      fault_event_flags     <= next_flt;
      thermistor_open_flags <= next_open;
      timer_fault_flags     <= next_tmr;
    end
  end

  // mask register, reserved bits kept as written
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      charge_event_masks <= `CEFMB_RST_MASK;
    end else if (reg_wr && reg_addr == `CEFMB_ADDR_MASK) begin
      charge_event_masks <= reg_wdata;
    end
  end

  // read returns the value before the clear takes effect
  always_comb begin
    case (reg_addr)
      `CEFMB_ADDR_CHG:  next_rdata = charge_event_flags;
      `CEFMB_ADDR_FLT:  next_rdata = fault_event_flags;
      `CEFMB_ADDR_OPEN: next_rdata = thermistor_open_flags;
      `CEFMB_ADDR_TMR:  next_rdata = timer_fault_flags;
      `CEFMB_ADDR_MASK: next_rdata = charge_event_masks;
      default:          next_rdata = `CEFMB_RD_NONE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= `CEFMB_RD_NONE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // only charge flags have a mask in this bank
  // the fault banks' masks live elsewhere, so they always pulse here
  assign next_irq =
    (|(rising(charge_event_flags, next_chg) & ~charge_event_masks)) ||
    (|rising(fault_event_flags, next_flt)) ||
    (|rising(thermistor_open_flags, next_open)) ||
    (|rising(timer_fault_flags, next_tmr));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_pulse <= 1'b0;
    end else begin
      irq_pulse <= next_irq;
    end
  end

  default clocking cefmb_cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  AST_FLT_CLR: assert property (
    clr_flt && set_flt == 8'h00 |=> fault_event_flags == 8'h00)
    else $error("fault flags not cleared by read");

  AST_RD_OLD: assert property (
    clr_flt |=> reg_rvalid && reg_rdata == $past(fault_event_flags))
    else $error("read did not return pre-clear value");

  AST_OPEN_RSV: assert property (
    thermistor_open_flags[7:1] == 7'h00)
    else $error("reserved open bits set");

  AST_TMR_CLR: assert property (
    clr_tmr && set_tmr == 8'h00 |=> timer_fault_flags == 8'h00)
    else $error("timer flags not cleared by read");

  AST_OVP_SET: assert property (
    input_overvoltage_event |=> fault_event_flags[`CEFMB_FLT_OVP])
    else $error("overvoltage not latched");

  AST_FLT_RSV: assert property (
    !fault_event_flags[`CEFMB_FLT_RSV])
    else $error("reserved fault bit set");

  AST_UVLO_EDGE: assert property (
    started && UVLO_PRINTED_POLARITY && $fell(battery_undervoltage_lockout)
    |=> fault_event_flags[`CEFMB_FLT_UVLO])
    else $error("lockout recovery not latched");

  AST_HOT_HOLD: assert property (
    therm_hot_entry ##1 !clr_flt [*2] |=> fault_event_flags[`CEFMB_FLT_HOT])
    else $error("hot entry lost before read");

  AST_OPEN_SET: assert property (
    therm_open_event |=> thermistor_open_flags[`CEFMB_OPEN_TS])
    else $error("open fault not latched");

  AST_TMR_RSV: assert property (
    !timer_fault_flags[`CEFMB_TMR_RSV_HI] &&
    !timer_fault_flags[`CEFMB_TMR_RSV_LO])
    else $error("reserved timer bit set");

  AST_MASK_WR: assert property (
    reg_wr && reg_addr == `CEFMB_ADDR_MASK
    |=> charge_event_masks == $past(reg_wdata))
    else $error("mask write not stored");

  AST_MASKED_QUIET: assert property (
    charge_event_masks == 8'hff && set_flt == 8'h00 &&
    set_open == 8'h00 && set_tmr == 8'h00 |=> !irq_pulse)
    else $error("masked event raised interrupt");

  AST_UNMASKED_IRQ: assert property (
    cv_entry_event && !charge_event_flags[`CEFMB_CHG_CV] &&
    !charge_event_masks[`CEFMB_CHG_CV] |=> irq_pulse)
    else $error("voltage mode entry gave no interrupt");

  AST_SET_WINS: assert property (
    clr_tmr && watchdog_expiry_event |=> timer_fault_flags[`CEFMB_TMR_WD])
    else $error("event lost in clearing read");

  AST_PG_POWERUP: assert property (
    pg_suppress |=> !charge_event_flags[`CEFMB_CHG_PG])
    else $error("power good flagged at powerup under lockout");

  AST_PG_CHANGE: assert property (
    started && $changed(input_power_good) |=>
    charge_event_flags[`CEFMB_CHG_PG])
    else $error("power good change not latched");

  AST_RVALID_ECHO: assert property (
    reg_rvalid == $past(reg_rd))
    else $error("read valid does not follow the read strobe");

  AST_FLT_NO_WR: assert property (
    reg_wr && !reg_rd && set_flt == 8'h00
    |=> fault_event_flags == $past(fault_event_flags))
    else $error("fault flags changed by a write");

  AST_SAFE_SET: assert property (
    safety_timer_expiry_event |=> timer_fault_flags[`CEFMB_TMR_SAFE])
    else $error("safety timer expiry not latched");

  AST_REG_SET: assert property (
    regulator_overcurrent_event |=> timer_fault_flags[`CEFMB_TMR_REG])
    else $error("regulator overcurrent not latched");

  AST_WAKE2_SET: assert property (
    button_wake_second_expiry |=> timer_fault_flags[`CEFMB_TMR_WAKE2])
    else $error("second wake timer expiry not latched");

  COV_READ_CLEAR: cover property (
    fault_event_flags != 8'h00 ##1 clr_flt ##1 fault_event_flags == 8'h00);
  COV_SET_WINS: cover property (clr_chg && set_chg != 8'h00);
  COV_IRQ: cover property (irq_pulse ##1 reg_rd);
  COV_MASKED_LATCH: cover property (
    charge_event_masks[`CEFMB_CHG_DONE] && charge_done_event ##1 !irq_pulse);

endmodule

// ===== verification/cefmb_host_model.sv
// host model driving the register strobes of the flag and mask bank
module cefmb_host_model
  import cefmb_pkg::*;
(
  input  wire logic        clock,
  output      logic        reg_rd,
  output      logic        reg_wr,
  output      cefmb_byte_t reg_addr,
  output      cefmb_byte_t reg_wdata,
  input  wire cefmb_byte_t reg_rdata,
  input  wire logic        reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b0;
    reg_addr  <= 8'h00;
    reg_wdata <= 8'h00;
  end

  // idle address inverted so a stale value never matches
  task automatic rd(input cefmb_byte_t a, output cefmb_byte_t d);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask

  task automatic wr(input cefmb_byte_t a, input cefmb_byte_t v);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~v;
  endtask
endmodule

// ===== verification/charger_event_flag_mask_bank_tb_top.sv
// self-checking bench for the flag and mask bank
module charger_event_flag_mask_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import cefmb_pkg::*;

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [19:0] ev    = '0;
  logic        reg_rd;
  logic        reg_wr;
  logic        reg_rvalid;
  logic        irq_pulse;
  cefmb_byte_t reg_addr;
  cefmb_byte_t reg_wdata;
  cefmb_byte_t reg_rdata;
  cefmb_byte_t d;
  int          n_mismatch = 0;
  int          compares = 0;
  // event index to register and expected flag byte
  localparam cefmb_byte_t ADDR [18] = '{8'h03, 8'h03, 8'h03, 8'h03,
    8'h03, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h05, 8'h06,
    8'h06, 8'h06, 8'h06, 8'h06, 8'h06};
  localparam cefmb_byte_t VAL [18] = '{8'h40, 8'h20, 8'h10, 8'h04,
    8'h02, 8'h80, 8'h20, 8'h08, 8'h04, 8'h02, 8'h01, 8'h01, 8'h40,
    8'h20, 8'h10, 8'h04, 8'h02, 8'h01};

  always #2 clock = ~clock;

  cefmb_top cefmb_top_inst (
    .clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .irq_pulse(irq_pulse),
    .cv_entry_event(ev[0]), .charge_done_event(ev[1]),
    .input_current_limit_event(ev[2]), .input_dpm_event(ev[3]),
    .thermal_regulation_event(ev[4]), .input_overvoltage_event(ev[5]),
    .battery_overcurrent_event(ev[6]), .therm_cold_entry(ev[7]),
    .therm_cool_entry(ev[8]), .therm_warm_entry(ev[9]),
    .therm_hot_entry(ev[10]), .therm_open_event(ev[11]),
    .watchdog_expiry_event(ev[12]), .safety_timer_expiry_event(ev[13]),
    .regulator_overcurrent_event(ev[14]),
    .button_wake_first_expiry(ev[15]),
    .button_wake_second_expiry(ev[16]),
    .button_reset_warning_expiry(ev[17]), .input_power_good(ev[18]),
    .battery_undervoltage_lockout(ev[19])
  );

  cefmb_host_model cefmb_host_model_inst (
    .clock(clock), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid)
  );

  task automatic chk(input string n, input cefmb_byte_t s,
                     input cefmb_byte_t e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask

  // drive one input, check the interrupt after the taking edge
  task automatic step(input int i, input logic v, input logic irq,
                      input logic back);
    @(posedge clock);
    ev[i] <= v;
    @(posedge clock);
    if (back)
      ev[i] <= ~v;
    #1;
    chk("irq_pulse", {7'h00, irq_pulse}, {7'h00, irq});
  endtask

  task automatic rdchk(input cefmb_byte_t a, input cefmb_byte_t e);
    cefmb_host_model_inst.rd(a, d);
    chk("reg_rdata", d, e);
  endtask

  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 3; a < 9; a++) begin
      rdchk(8'(a), 8'h00);
    end
    for (int i = 0; i < 18; i++) begin
      step(i, 1'b1, 1'b1, 1'b1);
      rdchk(ADDR[i], VAL[i]);
      rdchk(ADDR[i], 8'h00);
    end
    cefmb_host_model_inst.wr(8'h07, 8'hff);
    rdchk(8'h07, 8'hff);
    for (int i = 0; i < 5; i++) begin
      step(i, 1'b1, 1'b0, 1'b1);
    end
    rdchk(8'h03, 8'h76);
    cefmb_host_model_inst.wr(8'h07, 8'h40);
    step(1, 1'b1, 1'b1, 1'b1);
    rdchk(8'h03, 8'h20);
    step(18, 1'b1, 1'b1, 1'b0);
    rdchk(8'h03, 8'h01);
    cefmb_host_model_inst.wr(8'h07, 8'h01);
    step(18, 1'b0, 1'b0, 1'b0);
    rdchk(8'h03, 8'h01);
    // set in the clearing read cycle must survive
    fork
      rdchk(8'h04, 8'h00);
      step(10, 1'b1, 1'b1, 1'b1);
    join
    step(10, 1'b1, 1'b0, 1'b1);
    rdchk(8'h04, 8'h01);
    step(19, 1'b1, 1'b0, 1'b0);
    step(19, 1'b0, 1'b1, 1'b0);
    rdchk(8'h04, 8'h10);
    cefmb_host_model_inst.wr(8'h04, 8'hff);
    rdchk(8'h04, 8'h00);
    // second reset: power up with input good under lockout
    @(posedge clock);
    rst_n <= 1'b0;
    ev[18] <= 1'b1;
    ev[19] <= 1'b1;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    // powerup cycle under lockout must stay quiet
    @(posedge clock);
    #1;
    chk("irq_pulse", {7'h00, irq_pulse}, 8'h00);
    rdchk(8'h07, 8'h00);
    rdchk(8'h03, 8'h00);
    end_sim();
  end
endmodule
